// [logic/usb_event_pkg.sv]
// constants, field layouts and carrier types for the usb event and status block
// assumes a 32-bit apb register bus and one system clock shared with the link logic
package usb_event_pkg;

	// register byte offsets
	localparam logic [11:0] INT_ENABLE_OFS    = 12'h000;
	localparam logic [11:0] INT_STATUS_OFS    = 12'h004;
	localparam logic [11:0] FUNC_ADDR_OFS     = 12'h008;
	localparam logic [11:0] EP_STATUS_OFS     = 12'h00C;
	localparam logic [11:0] BUS_ATTR_OFS      = 12'h010;

	// reset values
	localparam logic [31:0] INT_ENABLE_RST    = 32'h00000000;
	localparam logic [31:0] INT_STATUS_RST    = 32'h00000000;
	localparam logic [6:0]  FUNC_ADDR_RST     = 7'h00;
	localparam logic [2:0]  EP_RESULT_RST     = 3'h0;
	localparam logic [3:0]  BUS_KIND_RST      = 4'h0;

	// interrupt status and enable bit positions
	localparam int          BUS_EVT_BIT       = 0;
	localparam int          TXN_EVT_BIT       = 1;
	localparam int          ATTACH_EVT_BIT    = 2;
	localparam int          WAKE_EVT_BIT      = 3;
	localparam int          IN_NAK_EN_BIT     = 15;
	localparam int          EP_FLAG_LSB       = 16;
	localparam int          SETUP_EVT_BIT     = 31;

	// endpoint status layout, function address and bus kind widths
	localparam int          EP_COUNT          = 8;
	localparam int          EP_RESULT_W       = 3;
	localparam int          EP_RESULT_LSB     = 8;
	localparam int          OVERRUN_BIT       = 7;
	localparam int          FUNC_ADDR_W       = 7;
	localparam int          BUS_KIND_W        = 4;

	// bus result encodings
	localparam logic [2:0]  RES_IN_ACK        = 3'h0;
	localparam logic [2:0]  RES_IN_NAK        = 3'h1;
	localparam logic [2:0]  RES_OUT_DATA0_ACK = 3'h2;
	localparam logic [2:0]  RES_OUT_DATA1_ACK = 3'h6;
	localparam logic [2:0]  RES_SETUP_ACK     = 3'h3;
	localparam logic [2:0]  RES_ISO_END       = 3'h7;

	// one finished transaction, reported by the link logic
	typedef struct packed {
		logic       valid;
		logic [2:0] ep;
		logic [2:0] result;
		logic       overrun;
	} txn_report_t;

	// bus level happenings, each flag a one-cycle pulse, plus the kind of the bus event
	typedef struct packed {
		logic       wake;
		logic       attach_detach;
		logic       bus_event;
		logic [3:0] bus_kind;
	} bus_report_t;

endpackage

// [logic/usb_device_event_status.sv]
// event flags, interrupt status, function address and endpoint bus status of a
// full-speed usb device controller, reached over apb.
// assumes the link logic reports transactions and bus events as one-cycle pulses
// synchronous to mclk_in, and that apb signals are synchronous to mclk_in.
`timescale 1ns/1ps

module usb_device_event_status #(
	parameter int ADDR_W = 12
) (
	input  wire logic                           mclk_in,
	input  wire logic                           resetn_in,
	input  wire logic                           psel_in,
	input  wire logic                           penable_in,
	input  wire logic                           pwrite_in,
	input  wire logic [ADDR_W-1:0]              paddr_in,
	input  wire logic [31:0]                    pwdata_in,
	input  wire logic [3:0]                     pstrb_in,
	output logic      [31:0]                    prdata_out,
	output logic                                pready_out,
	output logic                                pslverr_out,
	input  wire usb_event_pkg::txn_report_t     txn_in,
	input  wire usb_event_pkg::bus_report_t     bus_in,
	output logic [usb_event_pkg::FUNC_ADDR_W-1:0] function_address_out,
	output logic                                in_nak_report_enable_out,
	output logic                                irq_out
);

	// apb access decode
	logic                                   access_q;
	logic                                   err_q;
	logic [31:0]                            rdata_q;
	logic                                   commit;
	logic                                   wr_commit;
	logic                                   hit;
	logic [31:0]                            wmask;
	logic [31:0]                            rd_mux;

	// stored state
	logic [31:0]                            int_enable_q;
	logic [usb_event_pkg::EP_COUNT-1:0]     ep_flags_q;
	logic [usb_event_pkg::EP_COUNT-1:0]     ep_flags_d;
	logic                                   setup_flag_q;
	logic                                   setup_flag_d;
	logic                                   txn_flag_q;
	logic                                   txn_flag_d;
	logic                                   wake_flag_q;
	logic                                   attach_flag_q;
	logic                                   bus_flag_q;
	logic [usb_event_pkg::FUNC_ADDR_W-1:0]  func_addr_q;
	logic [usb_event_pkg::EP_COUNT-1:0][usb_event_pkg::EP_RESULT_W-1:0] ep_result_q;
	logic                                   overrun_q;
	logic [usb_event_pkg::BUS_KIND_W-1:0]   bus_kind_q;
	logic                                   irq_q;

	// event qualification
	logic                                   txn_report;
	logic [usb_event_pkg::EP_COUNT-1:0]     ep_set;
	logic                                   setup_set;
	logic [31:0]                            w1c;
	logic [31:0]                            irq_src_mask;
	logic [31:0]                            status_now;

	// one wait state: the access phase is answered on its second edge, so the
	// read mux is registered and outputs stay straight from flip-flops
	assign commit    = psel_in && penable_in && access_q;
	assign wr_commit = commit && pwrite_in && !err_q;

	always_comb begin
		wmask = 32'h00000000;
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{pstrb_in[b]}};
		end
	end

	always_comb begin
		hit = 1'b1;
		case (paddr_in[11:0])
			usb_event_pkg::INT_ENABLE_OFS: rd_mux = int_enable_q;
			usb_event_pkg::INT_STATUS_OFS: rd_mux = status_now;
			usb_event_pkg::FUNC_ADDR_OFS:  rd_mux = {25'h0000000, func_addr_q};
			usb_event_pkg::EP_STATUS_OFS:  rd_mux = {ep_result_q, overrun_q, 7'h00};
			usb_event_pkg::BUS_ATTR_OFS:   rd_mux = {28'h0000000, bus_kind_q};
			default: begin
				rd_mux = 32'h00000000;
				hit    = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			access_q <= 1'b0;
			err_q    <= 1'b0;
			rdata_q  <= 32'h00000000;
		end else if (psel_in && penable_in && !access_q) begin
			access_q <= 1'b1;
			// writes to the read-only status register are refused as well
			err_q    <= !hit || (pwrite_in &&
				paddr_in[11:0] == usb_event_pkg::EP_STATUS_OFS);
			rdata_q  <= pwrite_in ? 32'h00000000 : rd_mux;
		end else begin
			access_q <= 1'b0;
			err_q    <= 1'b0;
		end
	end

	assign prdata_out  = rdata_q;
	assign pready_out  = access_q;
	assign pslverr_out = err_q;

	// write-one-to-clear strobes, honouring byte lanes
	always_comb begin
		w1c = 32'h00000000;
		if (wr_commit && paddr_in[11:0] == usb_event_pkg::INT_STATUS_OFS) begin
			w1c = pwdata_in & wmask;
		end
	end

	assign txn_report = txn_in.valid &&
		(txn_in.result != usb_event_pkg::RES_IN_NAK || int_enable_q[usb_event_pkg::IN_NAK_EN_BIT]);
	assign setup_set  = txn_report && txn_in.result == usb_event_pkg::RES_SETUP_ACK;

	generate
		for (genvar e = 0; e < usb_event_pkg::EP_COUNT; e++) begin : g_ep
			assign ep_set[e] = txn_report && txn_in.ep == 3'(e);
			// set wins over a clear in the same cycle
			assign ep_flags_d[e] = ep_set[e] || (ep_flags_q[e] &&
				!w1c[usb_event_pkg::EP_FLAG_LSB + e] && !w1c[usb_event_pkg::TXN_EVT_BIT]);

			always_ff @(posedge mclk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					ep_result_q[e] <= usb_event_pkg::EP_RESULT_RST;
				end else if (ep_set[e]) begin
					ep_result_q[e] <= txn_in.result;
				end
			end
		end
	endgenerate

	assign setup_flag_d = setup_set || (setup_flag_q && !w1c[usb_event_pkg::SETUP_EVT_BIT]);

	always_comb begin
		if (txn_report) begin
			txn_flag_d = 1'b1;
		end else if (w1c[usb_event_pkg::TXN_EVT_BIT]) begin
			txn_flag_d = 1'b0;
		end else if (ep_flags_d == '0 && !setup_flag_d) begin
			txn_flag_d = 1'b0;
		end else begin
			txn_flag_d = txn_flag_q;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ep_flags_q <= '0;
		end else begin
			ep_flags_q <= ep_flags_d;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			setup_flag_q <= 1'b0;
		end else begin
			setup_flag_q <= setup_flag_d;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			txn_flag_q <= 1'b0;
		end else begin
			txn_flag_q <= txn_flag_d;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wake_flag_q <= 1'b0;
		end else begin
			wake_flag_q <= bus_in.wake ||
				(wake_flag_q && !w1c[usb_event_pkg::WAKE_EVT_BIT]);
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			attach_flag_q <= 1'b0;
		end else begin
			attach_flag_q <= bus_in.attach_detach ||
				(attach_flag_q && !w1c[usb_event_pkg::ATTACH_EVT_BIT]);
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bus_flag_q <= 1'b0;
		end else begin
			bus_flag_q <= bus_in.bus_event ||
				(bus_flag_q && !w1c[usb_event_pkg::BUS_EVT_BIT]);
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bus_kind_q <= usb_event_pkg::BUS_KIND_RST;
		end else if (bus_in.bus_event) begin
			bus_kind_q <= bus_in.bus_kind;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			overrun_q <= 1'b0;
		end else if (txn_report) begin
			overrun_q <= txn_in.overrun;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			func_addr_q <= usb_event_pkg::FUNC_ADDR_RST;
		end else if (wr_commit && paddr_in[11:0] == usb_event_pkg::FUNC_ADDR_OFS &&
			pstrb_in[0]) begin
			func_addr_q <= pwdata_in[usb_event_pkg::FUNC_ADDR_W-1:0];
		end
	end

	// enable register: same layout as status, plus the nak report control
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			int_enable_q <= usb_event_pkg::INT_ENABLE_RST;
		end else if (wr_commit && paddr_in[11:0] == usb_event_pkg::INT_ENABLE_OFS) begin
			int_enable_q <= (int_enable_q & ~wmask) | (pwdata_in & wmask);
		end
	end

	always_comb begin
		status_now = usb_event_pkg::INT_STATUS_RST;
		status_now[usb_event_pkg::SETUP_EVT_BIT] = setup_flag_q;
		status_now[usb_event_pkg::EP_FLAG_LSB +: usb_event_pkg::EP_COUNT] = ep_flags_q;
		status_now[usb_event_pkg::WAKE_EVT_BIT]   = wake_flag_q;
		status_now[usb_event_pkg::ATTACH_EVT_BIT] = attach_flag_q;
		status_now[usb_event_pkg::TXN_EVT_BIT]    = txn_flag_q;
		status_now[usb_event_pkg::BUS_EVT_BIT]    = bus_flag_q;
	end

	// interrupt sources: setup, endpoint flags and the four low flags;
	// bit 15 of the enable word is the nak report control, never a source
	always_comb begin
		irq_src_mask = '0;
		irq_src_mask[usb_event_pkg::SETUP_EVT_BIT] = 1'b1;
		irq_src_mask[usb_event_pkg::EP_FLAG_LSB +: usb_event_pkg::EP_COUNT] = '1;
		irq_src_mask[usb_event_pkg::WAKE_EVT_BIT] = 1'b1;
		irq_src_mask[usb_event_pkg::ATTACH_EVT_BIT] = 1'b1;
		irq_src_mask[usb_event_pkg::TXN_EVT_BIT] = 1'b1;
		irq_src_mask[usb_event_pkg::BUS_EVT_BIT] = 1'b1;
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_now & int_enable_q & irq_src_mask);
		end
	end

	assign irq_out                  = irq_q;
	assign function_address_out     = func_addr_q;
	assign in_nak_report_enable_out = int_enable_q[usb_event_pkg::IN_NAK_EN_BIT];

endmodule

// [bench/usb_event_status_asserts.sv]
// checker for the usb event and status block
// sees only the top module ports; bound at the foot of this file
`timescale 1ns/1ps

module usb_event_status_asserts #(
	parameter int ADDR_W = 12
) (
	input wire logic                             mclk_in,
	input wire logic                             resetn_in,
	input wire logic                             psel_in,
	input wire logic                             penable_in,
	input wire logic                             pwrite_in,
	input wire logic [ADDR_W-1:0]                paddr_in,
	input wire logic [31:0]                      pwdata_in,
	input wire logic [3:0]                       pstrb_in,
	input wire logic [31:0]                      prdata_out,
	input wire logic                             pready_out,
	input wire logic                             pslverr_out,
	input wire usb_event_pkg::txn_report_t       txn_in,
	input wire usb_event_pkg::bus_report_t       bus_in,
	input wire logic [6:0]                       function_address_out,
	input wire logic                             in_nak_report_enable_out,
	input wire logic                             irq_out
);
	logic acc;
	logic wacc;
	logic ev;
	logic clr;
	assign acc = psel_in && penable_in && pready_out;
	assign wacc = acc && pwrite_in;
	assign clr = wacc && (paddr_in == 12'h000 || paddr_in == 12'h004);
	// an enable write can raise the line just like an event
	assign ev = txn_in.valid || bus_in.wake || bus_in.attach_detach || bus_in.bus_event
		|| (wacc && paddr_in == 12'h000);

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	a_addr_write: assert property (wacc && paddr_in == 12'h008 && pstrb_in[0]
		|=> function_address_out == $past(pwdata_in[6:0])) else $error("address write lost");
	a_addr_hold: assert property (!(wacc && paddr_in == 12'h008)
		|=> $stable(function_address_out)) else $error("address changed unasked");
	a_addr_read: assert property (acc && !pwrite_in && paddr_in == 12'h008
		|-> prdata_out == {25'h0, function_address_out}) else $error("address readback");
	a_access_two: assert property (psel_in && penable_in && !$past(penable_in)
		|-> !pready_out ##1 pready_out) else $error("access length wrong");
	a_status_ro: assert property (wacc && paddr_in == 12'h00C |-> pslverr_out)
		else $error("status write accepted");
	a_unmapped_err: assert property (acc && !(paddr_in inside {12'h000, 12'h004,
		12'h008, 12'h00C, 12'h010}) |-> pslverr_out && prdata_out == 32'h0)
		else $error("unmapped access");
	a_nak_enable: assert property (wacc && paddr_in == 12'h000 && pstrb_in[1]
		|=> in_nak_report_enable_out == $past(pwdata_in[15])) else $error("nak enable");
	a_irq_rise: assert property ($rose(irq_out) |-> $past(ev, 2))
		else $error("irq rose without cause");
	a_irq_fall: assert property ($fell(irq_out) |-> $past(clr, 2))
		else $error("irq fell without clear");

	c_irq: cover property ($rose(irq_out));
	c_err: cover property (pslverr_out);
	c_nak: cover property (in_nak_report_enable_out && txn_in.valid);
endmodule

bind usb_device_event_status usb_event_status_asserts #(.ADDR_W(ADDR_W)) i_usb_event_status_asserts (.*);

// [bench/usb_host_model.sv]
// link-side model standing in for host traffic seen through the link logic
// assumes reports are one-cycle pulses synchronous to mclk_in
`timescale 1ns/1ps

module usb_host_model (
	input  wire logic                  mclk_in,
	output usb_event_pkg::txn_report_t txn_out,
	output usb_event_pkg::bus_report_t bus_out
);
	initial begin
		txn_out = '0;
		bus_out = '0;
	end

	// one idle cycle after each report, so no signal is driven twice at one edge
	task automatic txn(input logic [2:0] ep, input logic [2:0] res, input logic ovr);
		txn_out <= {1'b1, ep, res, ovr};
		@(posedge mclk_in);
		txn_out <= {1'b0, ~ep, ~res, ~ovr};
		@(posedge mclk_in);
	endtask

	task automatic bus(input logic w, input logic a, input logic b, input logic [3:0] k);
		bus_out <= {w, a, b, k};
		@(posedge mclk_in);
		bus_out <= {3'b000, ~k};
		@(posedge mclk_in);
	endtask
endmodule

// [bench/usb_device_event_status_bench.sv]
// self-checking bench for the usb event and status block
// assumes the host model drives link reports and apb tasks act as software
`timescale 1ns/1ps

module usb_device_event_status_bench;
	logic        mclk_in, resetn_in, psel_in, penable_in, pwrite_in, e;
	logic        pready_out, pslverr_out, in_nak_report_enable_out, irq_out;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, r, ep;
	logic [3:0]  pstrb_in;
	logic [6:0]  function_address_out;
	logic [2:0]  codes [8] = '{3'h0, 3'h2, 3'h6, 3'h3, 3'h7, 3'h0, 3'h2, 3'h6};
	int          n_errors = 0;
	int          checks = 0;
	usb_event_pkg::txn_report_t txn_in;
	usb_event_pkg::bus_report_t bus_in;

	usb_device_event_status i_usb_device_event_status (.*);
	usb_host_model i_usb_host_model (.mclk_in(mclk_in), .txn_out(txn_in), .bus_out(bus_in));

	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		logic got;
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 16);
		got = pready_out === 1'b1;
		r = prdata_out;
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		// one idle edge, so the next call never drives psel twice in one step
		@(posedge mclk_in);
		// a slave that never answers ends the run
		if (!got) begin
			n_errors++;
			stop_test();
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask

	initial begin
		resetn_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 12'h000;
		pwdata_in = 32'h0;
		pstrb_in = 4'hF;
		repeat (8) @(posedge mclk_in);
		resetn_in <= 1'b1;
		@(posedge mclk_in);
		rd(12'h008, 32'h0);
		rd(12'h00C, 32'h0);
		apb(1'b1, 12'h008, 32'hFFFFFFFF);
		chk({25'h0, function_address_out}, 32'h7F);
		rd(12'h008, 32'h7F);
		// a write without byte lane 0 must leave the address alone
		pstrb_in <= 4'hE;
		apb(1'b1, 12'h008, 32'h0);
		pstrb_in <= 4'hF;
		rd(12'h008, 32'h7F);
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		chk({31'h0, e}, 32'h1);
		rd(12'h00C, 32'h0);
		rd(12'h014, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, 12'h000, 32'h80FF000F);
		i_usb_host_model.txn(3'h3, 3'h1, 1'b0);
		rd(12'h004, 32'h0);
		ep = 32'h0;
		for (int i = 0; i < 8; i++) begin
			i_usb_host_model.txn(i[2:0], codes[i], i == 7);
			ep |= 32'(codes[i]) << (8 + 3 * i);
		end
		rd(12'h00C, ep | 32'h80);
		rd(12'h004, 32'h80FF0002);
		chk({31'h0, irq_out}, 32'h1);
		apb(1'b1, 12'h004, 32'h00020000);
		rd(12'h004, 32'h80FD0002);
		apb(1'b1, 12'h004, 32'h00000002);
		rd(12'h004, 32'h80000000);
		apb(1'b1, 12'h004, 32'h80000000);
		rd(12'h004, 32'h0);
		chk({31'h0, irq_out}, 32'h0);
		i_usb_host_model.txn(3'h2, 3'h2, 1'b0);
		ep = (ep & ~32'h0001C000) | 32'h00008000;
		rd(12'h00C, ep);
		apb(1'b1, 12'h004, 32'h00040000);
		rd(12'h004, 32'h0);
		apb(1'b1, 12'h000, 32'h80FF800F);
		chk({31'h0, in_nak_report_enable_out}, 32'h1);
		i_usb_host_model.txn(3'h5, 3'h1, 1'b0);
		ep = (ep & ~32'h03800000) | 32'h00800000;
		rd(12'h00C, ep);
		rd(12'h004, 32'h00200002);
		apb(1'b1, 12'h004, 32'h00200002);
		i_usb_host_model.bus(1'b1, 1'b1, 1'b1, 4'h5);
		rd(12'h004, 32'h0000000D);
		rd(12'h010, 32'h5);
		chk({31'h0, irq_out}, 32'h1);
		apb(1'b1, 12'h000, 32'h0);
		rd(12'h004, 32'h0000000D);
		chk({31'h0, irq_out}, 32'h0);
		apb(1'b1, 12'h004, 32'h0000000D);
		rd(12'h004, 32'h0);
		stop_test();
	end
endmodule
